// ===== rtl/code_area_ram_remap.sv
// Code area remap control with AXI4-Lite register access
`timescale 1ns/1ns
module code_area_ram_remap #(
    parameter int ADDR_W = 16,
    parameter logic [7:0] SWI_OPCODE = 8'hff
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic fetchReq,
    input wire logic [15:0] fetchAddr,
    output logic fetchValid,
    output logic fetchFromRam,
    output logic fetchFromFlash,
    output logic fetchSwi,
    output logic [7:0] fetchSwiData,
    input wire logic vectorReq,
    input wire logic [15:0] vectorAddr,
    output logic vectorValid,
    output logic [15:0] vectorPhysAddr,
    input wire logic dataReq,
    input wire logic [15:0] dataAddr,
    output logic dataValid,
    output logic dataFromRam,
    input wire logic serialProgMode,
    input wire logic resetFlagClearStaged,
    output logic resetFlagClear,
    output logic resetDisable
);
    // Register byte addresses need fourteen bits at least
    generate
        if (ADDR_W < 14 || ADDR_W > 32) begin : g_bad_width
            $error("ADDR_W must lie between 14 and 32");
        end
    endgenerate

    localparam logic [ADDR_W-1:0] STAGING_ADDR = ADDR_W'({16'h0000, code_map_pkg::IDX_STAGING} << code_map_pkg::WORD_SHIFT);
    localparam logic [ADDR_W-1:0] COMMIT_ADDR = ADDR_W'({16'h0000, code_map_pkg::IDX_COMMIT} << code_map_pkg::WORD_SHIFT);
    localparam logic [ADDR_W-1:0] WORD_MASK = ~ADDR_W'(3);

    code_map_if map ();

    logic [2:0] stagedBits;
    logic ramMapCommitted;
    logic vecRelocCommitted;

    logic awHeld;
    logic [ADDR_W-1:0] awAddrQ;
    logic wHeld;
    logic [7:0] wDataQ;
    logic wLane0Q;

    // Write channel: address and data are caught independently, then executed together
    wire awTake;
    wire wTake;
    wire wrGo;
    wire wrHitStaging;
    wire wrHitCommit;
    wire wrMapped;
    wire stagingWrite;
    wire commitAll;
    wire commitRstOnly;
    wire [1:0] next_bresp;

    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready = !wHeld && !s_axi_bvalid;
    assign awTake = s_axi_awvalid && s_axi_awready;
    assign wTake = s_axi_wvalid && s_axi_wready;
    assign wrGo = awHeld && wHeld && !s_axi_bvalid;
    assign wrHitStaging = (awAddrQ & WORD_MASK) == STAGING_ADDR;
    assign wrHitCommit = (awAddrQ & WORD_MASK) == COMMIT_ADDR;
    assign wrMapped = wrHitStaging || wrHitCommit;
    assign next_bresp = wrMapped ? code_map_pkg::RESP_OKAY : code_map_pkg::RESP_SLVERR;
    // A write without byte lane 0 carries no register byte and is ignored
    assign stagingWrite = wrGo && wrHitStaging && wLane0Q;
    // Key must arrive as one whole byte; anything else leaves the mapping alone
    assign commitAll = wrGo && wrHitCommit && wLane0Q && (wDataQ == code_map_pkg::KEY_COMMIT_ALL);
    assign commitRstOnly = wrGo && wrHitCommit && wLane0Q && (wDataQ == code_map_pkg::KEY_COMMIT_RSTDIS);

    always_ff @(posedge clk) begin
        if (rst) begin
            awHeld <= 1'b0;
            awAddrQ <= '0;
        end else if (awTake) begin
            awHeld <= 1'b1;
            awAddrQ <= s_axi_awaddr;
        end else if (wrGo) begin
            awHeld <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wHeld <= 1'b0;
            wDataQ <= 8'h00;
            wLane0Q <= 1'b0;
        end else if (wTake) begin
            wHeld <= 1'b1;
            wDataQ <= s_axi_wdata[7:0];
            wLane0Q <= s_axi_wstrb[0];
        end else if (wrGo) begin
            wHeld <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= code_map_pkg::RESP_OKAY;
        end else if (wrGo) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= next_bresp;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Staging register: only the three mapping bits exist
    always_ff @(posedge clk) begin
        if (rst) begin
            stagedBits <= code_map_pkg::STAGING_RESET;
        end else if (stagingWrite) begin
            stagedBits <= wDataQ[code_map_pkg::FIELD_W-1:0];
        end
    end

    // Committed mapping; reset leaves RAM out of the code space
    always_ff @(posedge clk) begin
        if (rst) begin
            ramMapCommitted <= 1'b0;
            vecRelocCommitted <= 1'b0;
            resetFlagClear <= 1'b0;
        end else if (commitAll) begin
            ramMapCommitted <= stagedBits[code_map_pkg::BIT_RAMMAP];
            vecRelocCommitted <= stagedBits[code_map_pkg::BIT_VRELOC];
            resetFlagClear <= resetFlagClearStaged;
        end
    end

    // Reset disable also has its own key so it can be moved without touching the map
    always_ff @(posedge clk) begin
        if (rst) begin
            resetDisable <= 1'b0;
        end else if (commitAll || commitRstOnly) begin
            resetDisable <= stagedBits[code_map_pkg::BIT_RSTDIS];
        end
    end

    // Read channel: the commit address reads back as the status register
    wire arTake;
    wire rdHitStaging;
    wire rdHitStatus;
    wire [31:0] stagingView;
    wire [31:0] statusView;
    wire [31:0] next_rdata;
    wire [1:0] next_rresp;

    assign s_axi_arready = !s_axi_rvalid;
    assign arTake = s_axi_arvalid && s_axi_arready;
    assign rdHitStaging = (s_axi_araddr & WORD_MASK) == STAGING_ADDR;
    assign rdHitStatus = (s_axi_araddr & WORD_MASK) == COMMIT_ADDR;
    assign stagingView = {29'h0000000, stagedBits};
    assign statusView = {29'h0000000, vecRelocCommitted, ramMapCommitted, resetDisable};
    assign next_rdata = rdHitStaging ? stagingView : (rdHitStatus ? statusView : 32'h00000000);
    assign next_rresp = (rdHitStaging || rdHitStatus) ? code_map_pkg::RESP_OKAY : code_map_pkg::RESP_SLVERR;

    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= code_map_pkg::RESP_OKAY;
        end else if (arTake) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Fetch path decode
    assign map.fetchAddr = fetchAddr;
    assign map.vectorAddr = vectorAddr;
    assign map.ramMapped = ramMapCommitted || serialProgMode;
    assign map.vectorReloc = vecRelocCommitted;

    code_fetch_decode u_decode (
        .map(map.decoder)
    );

    wire isRam;
    wire isFlash;
    wire isSwi;
    wire dataInRam;

    assign isRam = map.target == code_map_pkg::TGT_RAM;
    assign isFlash = map.target == code_map_pkg::TGT_FLASH;
    assign isSwi = map.target == code_map_pkg::TGT_SWI;
    // Data space sees RAM whatever the code map says
    assign dataInRam = (dataAddr >= code_map_pkg::RAM_LO) && (dataAddr <= code_map_pkg::RAM_HI);

    always_ff @(posedge clk) begin
        if (rst) begin
            fetchValid <= 1'b0;
            fetchFromRam <= 1'b0;
            fetchFromFlash <= 1'b0;
            fetchSwi <= 1'b0;
            fetchSwiData <= 8'h00;
        end else begin
            fetchValid <= fetchReq;
            fetchFromRam <= fetchReq && isRam;
            fetchFromFlash <= fetchReq && isFlash;
            fetchSwi <= fetchReq && isSwi;
            fetchSwiData <= (fetchReq && isSwi) ? SWI_OPCODE : 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            vectorValid <= 1'b0;
            vectorPhysAddr <= 16'h0000;
        end else begin
            vectorValid <= vectorReq;
            if (vectorReq) begin
                vectorPhysAddr <= map.vectorPhys;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dataValid <= 1'b0;
            dataFromRam <= 1'b0;
        end else begin
            dataValid <= dataReq;
            dataFromRam <= dataReq && dataInRam;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_reset_clears_map:
    assert property (@(posedge clk) disable iff (1'b0)
        rst |=> !ramMapCommitted && !vecRelocCommitted && stagedBits == code_map_pkg::STAGING_RESET)
        else $error("Mapping not cleared by reset");

    a_ram_fetch_decode:
    assert property (fetchReq && map.fetchInRam && ramMapCommitted |=> fetchValid && fetchFromRam && !fetchSwi)
        else $error("Mapped RAM fetch not served from RAM");

    a_serial_forces_ram:
    assert property (fetchReq && map.fetchInRam && serialProgMode |=> fetchFromRam)
        else $error("Serial mode fetch not served from RAM");

    a_swi_when_unmapped:
    assert property (fetchReq && map.fetchInRam && !ramMapCommitted && !serialProgMode
        |=> fetchSwi && !fetchFromRam && fetchSwiData == SWI_OPCODE)
        else $error("Unmapped RAM fetch did not return trap opcode");

    a_default_vectors:
    assert property (vectorReq && !vecRelocCommitted |=> vectorValid && vectorPhysAddr == $past(vectorAddr))
        else $error("Vector moved while relocation is off");

    a_reloc_vectors:
    assert property (vectorReq && vecRelocCommitted && vectorAddr >= code_map_pkg::VCALL_LO
        && vectorAddr <= code_map_pkg::VCALL_HI
        |=> vectorPhysAddr == $past(vectorAddr) - code_map_pkg::RELOC_OFFSET)
        else $error("Vector call entry not relocated to RAM");

    a_reset_vector_fixed:
    assert property (vectorReq && vectorAddr >= code_map_pkg::RESET_VEC_LO |=> vectorPhysAddr == $past(vectorAddr))
        else $error("Reset vector was relocated");

    a_map_holds_nokey:
    assert property (!commitAll |=> $stable(ramMapCommitted) && $stable(vecRelocCommitted))
        else $error("Mapping changed without the key");

    a_key_commits_all:
    assert property (commitAll |=> ramMapCommitted == $past(stagedBits[code_map_pkg::BIT_RAMMAP])
        && vecRelocCommitted == $past(stagedBits[code_map_pkg::BIT_VRELOC])
        && resetFlagClear == $past(resetFlagClearStaged))
        else $error("Key write did not commit staged bits");

    a_rstdis_held:
    assert property (!commitAll && !commitRstOnly |=> $stable(resetDisable))
        else $error("Reset disable changed without a key");

    a_read_upper_zero:
    assert property (arTake |=> s_axi_rvalid && s_axi_rdata[31:3] == 29'h0000000)
        else $error("Upper read bits not zero");

    a_data_ram_always:
    assert property (dataReq && dataInRam |=> dataValid && dataFromRam)
        else $error("Data access to RAM not decoded");
endmodule

// ===== rtl/code_map_pkg.sv
// Constants and types shared by the code area remap logic
package code_map_pkg;
    // Register indices; byte address is the index shifted left by two
    localparam logic [15:0] IDX_STAGING = 16'h0fde;
    localparam logic [15:0] IDX_COMMIT = 16'h0fdf;
    localparam int WORD_SHIFT = 2;

    // Field positions of the staging and status registers
    localparam int BIT_VRELOC = 2;
    localparam int BIT_RAMMAP = 1;
    localparam int BIT_RSTDIS = 0;
    localparam int FIELD_W = 3;
    localparam logic [2:0] STAGING_RESET = 3'h0;

    // Commit key bytes
    localparam logic [7:0] KEY_COMMIT_ALL = 8'hd4;
    localparam logic [7:0] KEY_COMMIT_RSTDIS = 8'hb2;

    // Code and data space windows
    localparam logic [15:0] RAM_LO = 16'h0040;
    localparam logic [15:0] RAM_HI = 16'h083f;
    localparam logic [15:0] FLASH_LO = 16'h8000;
    localparam logic [15:0] VCALL_LO = 16'hffa0;
    localparam logic [15:0] VCALL_HI = 16'hffbf;
    localparam logic [15:0] IVEC_LO = 16'hffcc;
    localparam logic [15:0] IVEC_HI = 16'hffff;
    localparam logic [15:0] RESET_VEC_LO = 16'hfffe;
    localparam logic [15:0] RELOC_OFFSET = 16'hfe00;

    // Where an instruction fetch is served
    typedef enum logic [3:0] {
        TGT_RAM = 4'b0001,
        TGT_FLASH = 4'b0010,
        TGT_SWI = 4'b0100,
        TGT_OTHER = 4'b1000
    } fetch_target_e;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== rtl/code_map_if.sv
// Signals between the register side and the fetch decoder
`timescale 1ns/1ns
interface code_map_if;
    logic [15:0] fetchAddr;
    logic [15:0] vectorAddr;
    logic ramMapped;
    logic vectorReloc;
    logic fetchInRam;
    code_map_pkg::fetch_target_e target;
    logic [15:0] vectorPhys;

    modport decoder (
        input fetchAddr, vectorAddr, ramMapped, vectorReloc,
        output fetchInRam, target, vectorPhys
    );
    modport owner (
        output fetchAddr, vectorAddr, ramMapped, vectorReloc,
        input fetchInRam, target, vectorPhys
    );
endinterface

// ===== rtl/code_fetch_decode.sv
// Combinational decoder for instruction and vector fetch addresses
`timescale 1ns/1ns
module code_fetch_decode (
    code_map_if.decoder map
);
    wire inRam;
    wire inFlash;
    wire inVcall;
    wire inIvec;
    wire isResetVec;
    wire relocHit;

    assign inRam = (map.fetchAddr >= code_map_pkg::RAM_LO) && (map.fetchAddr <= code_map_pkg::RAM_HI);
    assign inFlash = map.fetchAddr >= code_map_pkg::FLASH_LO;
    assign map.fetchInRam = inRam;

    // Unmapped RAM window hands the core a trap opcode rather than stale data
    assign map.target = inRam ? (map.ramMapped ? code_map_pkg::TGT_RAM : code_map_pkg::TGT_SWI) :
        (inFlash ? code_map_pkg::TGT_FLASH : code_map_pkg::TGT_OTHER);

    assign inVcall = (map.vectorAddr >= code_map_pkg::VCALL_LO) && (map.vectorAddr <= code_map_pkg::VCALL_HI);
    assign inIvec = (map.vectorAddr >= code_map_pkg::IVEC_LO) && (map.vectorAddr <= code_map_pkg::IVEC_HI);
    assign isResetVec = map.vectorAddr >= code_map_pkg::RESET_VEC_LO;
    // Reset vector never moves, so a broken RAM image cannot stop the part from booting
    assign relocHit = map.vectorReloc && (inVcall || (inIvec && !isResetVec));
    assign map.vectorPhys = relocHit ? (map.vectorAddr - code_map_pkg::RELOC_OFFSET) : map.vectorAddr;
endmodule

// ===== dv/cpu_fetch_model.sv
// Model of the processor fetch path that faces the code area remap block
`timescale 1ns/1ns
module cpu_fetch_model (
    input wire logic clk,
    output logic fetchReq,
    output logic [15:0] fetchAddr,
    input wire logic fetchValid,
    input wire logic fetchFromRam,
    input wire logic fetchFromFlash,
    input wire logic fetchSwi,
    input wire logic [7:0] fetchSwiData,
    output logic vectorReq,
    output logic [15:0] vectorAddr,
    input wire logic [15:0] vectorPhysAddr,
    output logic dataReq,
    output logic [15:0] dataAddr,
    input wire logic dataFromRam
);
    initial begin
        fetchReq = 1'b0;
        vectorReq = 1'b0;
        dataReq = 1'b0;
        fetchAddr = 16'h0000;
        vectorAddr = 16'h0000;
        dataAddr = 16'h0000;
    end

    // Code, vector and data requests go out together; the answers stand for one cycle, but vectorPhysAddr holds until the next vector request
    task automatic cycle(input logic [15:0] a, output logic [3:0] res, output logic [7:0] op,
                         output logic [15:0] phys, output logic fromRam);
        @(posedge clk);
        fetchReq <= 1'b1;
        vectorReq <= 1'b1;
        dataReq <= 1'b1;
        fetchAddr <= a;
        vectorAddr <= a;
        dataAddr <= a;
        @(posedge clk);
        fetchReq <= 1'b0;
        vectorReq <= 1'b0;
        dataReq <= 1'b0;
        // Released address lines show the inverse, so a stale address cannot pass for a live one
        fetchAddr <= ~a;
        vectorAddr <= ~a;
        dataAddr <= ~a;
        #1;
        res = {fetchValid, fetchFromRam, fetchFromFlash, fetchSwi};
        op = fetchSwiData;
        phys = vectorPhysAddr;
        fromRam = dataFromRam;
    endtask
endmodule

// ===== dv/testbench.sv
// Self-checking bench for the code area remap block
`timescale 1ns/1ns
module testbench;
    localparam logic [7:0] SOFTWARE_INTERRUPT_OPCODE = 8'hcd;
    localparam logic [15:0] STG = {code_map_pkg::IDX_STAGING[13:0], 2'b00};
    localparam logic [15:0] CMT = {code_map_pkg::IDX_COMMIT[13:0], 2'b00};
    localparam logic [3:0] F_RAM = 4'b1100;
    localparam logic [3:0] F_FLASH = 4'b1010;
    localparam logic [3:0] F_SWI = 4'b1001;
    localparam logic [3:0] F_NONE = 4'b1000;
    logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [15:0] awaddr, araddr, fAddr, vAddr, dAddr, vPhys, vp;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb, f;
    logic [1:0] bresp, rresp, resp;
    logic fReq, fValid, fRam, fFlash, fSwi, vReq, vValid, dReq, dValid, dRam, serial, flagStaged;
    logic flagClear, rstDis, dr;
    logic [7:0] swiData, op;
    int miscompares = 0;
    int n_compared = 0;

    code_area_ram_remap #(.ADDR_W(16), .SWI_OPCODE(SOFTWARE_INTERRUPT_OPCODE)) code_area_ram_remap_inst (.clk(clk), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .fetchReq(fReq), .fetchAddr(fAddr), .fetchValid(fValid),
        .fetchFromRam(fRam), .fetchFromFlash(fFlash), .fetchSwi(fSwi), .fetchSwiData(swiData),
        .vectorReq(vReq), .vectorAddr(vAddr), .vectorValid(vValid), .vectorPhysAddr(vPhys),
        .dataReq(dReq), .dataAddr(dAddr), .dataValid(dValid), .dataFromRam(dRam), .serialProgMode(serial),
        .resetFlagClearStaged(flagStaged), .resetFlagClear(flagClear), .resetDisable(rstDis));

    cpu_fetch_model cpu_fetch_model_inst (.clk(clk), .fetchReq(fReq), .fetchAddr(fAddr),
        .fetchValid(fValid), .fetchFromRam(fRam), .fetchFromFlash(fFlash), .fetchSwi(fSwi),
        .fetchSwiData(swiData), .vectorReq(vReq), .vectorAddr(vAddr), .vectorPhysAddr(vPhys),
        .dataReq(dReq), .dataAddr(dAddr), .dataFromRam(dRam));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Handshakes are judged mid-cycle, where only registered state can have moved
    task automatic axi_write(input logic [15:0] a, input logic [7:0] d);
        logic awT, wT, bT;
        int n;
        // Start on a fresh edge so a back-to-back call never reassigns bready in the same step
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= 4'h1;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        bT = 1'b0;
        n = 0;
        while (!bT && n < 100) begin
            @(negedge clk);
            awT = awvalid && awready;
            wT = wvalid && wready;
            bT = bvalid && bready;
            resp = bresp;
            @(posedge clk);
            if (awT) awvalid <= 1'b0;
            if (wT) wvalid <= 1'b0;
            n++;
        end
        bready <= 1'b0;
        if (!bT) miscompares++;
    endtask

    task automatic axi_read(input logic [15:0] a);
        logic arT, rT;
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        rT = 1'b0;
        n = 0;
        while (!rT && n < 100) begin
            @(negedge clk);
            arT = arvalid && arready;
            rT = rvalid && rready;
            rd = rdata;
            resp = rresp;
            @(posedge clk);
            if (arT) arvalid <= 1'b0;
            n++;
        end
        rready <= 1'b0;
        if (!rT) miscompares++;
    endtask

    task automatic go(input logic [15:0] a);
        cpu_fetch_model_inst.cycle(a, f, op, vp, dr);
    endtask

    task automatic test_reset();
        axi_read(STG);
        check(rd, 32'h0);
        check(resp, code_map_pkg::RESP_OKAY);
        axi_read(CMT);
        check(rd, 32'h0);
        go(16'h0040);
        check(f, F_SWI);
        check(op, SOFTWARE_INTERRUPT_OPCODE);
        check(dr, 1'b1);
        check(vp, 16'h0040);
        check({vValid, dValid}, 2'b11);
        go(16'h083f);
        check(f, F_SWI);
        go(16'hffa0);
        check(vp, 16'hffa0);
        check(f, F_FLASH);
        go(16'hffcc);
        check(vp, 16'hffcc);
        axi_read(16'h0100);
        check(rd, 32'h0);
        check(resp, code_map_pkg::RESP_SLVERR);
        $display("test_reset done");
    endtask

    task automatic test_staging();
        axi_write(STG, 8'hff);
        check(resp, code_map_pkg::RESP_OKAY);
        axi_write(16'h0100, 8'h00);
        check(resp, code_map_pkg::RESP_SLVERR);
        axi_read(STG);
        check(rd, 32'h7);
        axi_read(CMT);
        check(rd, 32'h0);
        go(16'h0040);
        check(f, F_SWI);
        axi_write(CMT, 8'h55);
        check(resp, code_map_pkg::RESP_OKAY);
        axi_read(CMT);
        check(rd, 32'h0);
        check({rstDis, flagClear}, 2'b00);
        $display("test_staging done");
    endtask

    task automatic test_commit();
        logic [15:0] va [6] = '{16'hffa0, 16'hffbf, 16'hffcc, 16'hfffd, 16'hfffe, 16'hffff};
        logic [15:0] ve [6] = '{16'h01a0, 16'h01bf, 16'h01cc, 16'h01fd, 16'hfffe, 16'hffff};
        flagStaged <= 1'b1;
        axi_write(CMT, code_map_pkg::KEY_COMMIT_ALL);
        flagStaged <= 1'b0;
        axi_read(CMT);
        check(rd, 32'h7);
        check({rstDis, flagClear}, 2'b11);
        go(16'h0040);
        check(f, F_RAM);
        go(16'h083f);
        check(f, F_RAM);
        go(16'h0840);
        check(f, F_NONE);
        check(dr, 1'b0);
        go(16'h003f);
        check(f, F_NONE);
        go(16'h8000);
        check(f, F_FLASH);
        for (int i = 0; i < 6; i++) begin
            go(va[i]);
            check(vp, ve[i]);
        end
        $display("test_commit done");
    endtask

    task automatic test_serial_key();
        // Relocation stays set so a loader never sees vectors in the boot region
        axi_write(STG, 8'h04);
        axi_write(CMT, code_map_pkg::KEY_COMMIT_ALL);
        go(16'h0040);
        check(f, F_SWI);
        serial <= 1'b1;
        go(16'h0040);
        check(f, F_RAM);
        serial <= 1'b0;
        axi_write(STG, 8'h05);
        axi_write(CMT, code_map_pkg::KEY_COMMIT_RSTDIS);
        check(rstDis, 1'b1);
        axi_read(CMT);
        check(rd, 32'h5);
        go(16'hffa0);
        check(vp, 16'h01a0);
        $display("test_serial_key done");
    endtask

    initial begin
        rst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready, serial, flagStaged} = 7'h0;
        awaddr = 16'h0;
        araddr = 16'h0;
        wdata = 32'h0;
        wstrb = 4'h0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        test_reset();
        test_staging();
        test_commit();
        test_serial_key();
        summarize();
    end

    // The whole run finishes in about a hundred cycles; this limit leaves ample margin
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        summarize();
    end
endmodule
